// ### bench/bsn_exec_asserts.sv
/*
 * Checker for bsn_exec: bus-level relations seen at the top ports.
 * Assumes the register map in bsn_pkg and a zero-wait AHB-Lite slave.
 */
`timescale 1ns/1ps
`default_nettype none

module bsn_exec_asserts
    import bsn_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // watched bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata
);
    // ------------------------------------------------------------
    // helper decode
    // ------------------------------------------------------------
    logic       ins_dp;
    logic [3:0] idle_cnt;
    wire        ap       = hsel & htrans[1] & hready;
    wire        rd_ap    = ap & ~hwrite;
    wire        ins_ap   = ap & hwrite & (haddr == {24'h0, OFS_INSTR});
    wire [3:0]  next_cnt = ins_dp ? 4'h0 :
                           (idle_cnt == 4'hF) ? 4'hF : idle_cnt + 4'h1;

    // cycles since the last instruction write; saturates, safe after reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ins_dp   <= 1'b0;
            idle_cnt <= 4'hF;
        end
        else
        begin
            ins_dp   <= ins_ap;
            idle_cnt <= next_cnt;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    ready_high_a: assert property (hreadyout)
        else $error("slave inserted a wait state");
    resp_okay_a: assert property (!hresp)
        else $error("slave gave an error response");
    rdata_hold_a: assert property (!rd_ap |=> $stable(hrdata))
        else $error("read data moved without a read");
    acc_width_a: assert property (rd_ap && haddr == {24'h0, OFS_ACC}
        |=> hrdata[31:8] == 24'h0) else $error("accumulator too wide");
    bank_width_a: assert property (rd_ap && haddr == {24'h0, OFS_BANK}
        |=> hrdata[31:4] == 28'h0) else $error("bank pointer too wide");
    index_width_a: assert property (
        rd_ap && haddr == {24'h0, OFS_INDEX}
        |=> hrdata[31:12] == 20'h0) else $error("index base too wide");
    flags_width_a: assert property (
        rd_ap && haddr == {24'h0, OFS_FLAGS}
        |=> hrdata[31:5] == 27'h0) else $error("flags too wide");
    unmapped_zero_a: assert property (rd_ap && haddr[31:8] != 24'h0
        |=> hrdata == 32'h0) else $error("unmapped read not zero");
    // four counted edges cover Q1..Q4, so the fifth sample must be idle
    idle_status_a: assert property (rd_ap && idle_cnt >= 4'h4
        && haddr == {24'h0, OFS_STATUS} |=> !hrdata[STAT_BUSY_BIT])
        else $error("still busy after one instruction cycle");
endmodule : bsn_exec_asserts

bind bsn_exec bsn_exec_asserts u_chk (.clk, .rst_n, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata);

`default_nettype wire

// ### bench/tb.sv
/*
 * Testbench for bsn_exec: runs both instructions through the register bus.
 * Assumes the bsn_pkg map; file memory holds X until written.
 */
`timescale 1ns/1ps
`default_nettype none

module tb
    import bsn_pkg::*;
;
    logic        clk, rst_n, hsel, hwrite;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata;
    wire         hready, hreadyout, hresp;
    wire  [31:0] hrdata;
    int          miscompares, n_compared;

    // single slave: its ready is the bus ready
    assign hready = hreadyout;
    bsn_exec u_dut (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hreadyout, .hresp, .hrdata);

    // ------------------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------------------
    task automatic give_verdict;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // bounded wait for ready at a rising edge
    task automatic wait_rdy;
        for (int i = 0; i < 9; i++)
        begin
            @(posedge clk);
            if (hready === 1'b1) return;
        end
        miscompares++;
        $display("BAD %0t ready never came", $time);
        give_verdict;
    endtask : wait_rdy

    task automatic bus(input logic [31:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] q);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= w;
        wait_rdy;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy;
        q = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus({24'h0, a}, 1'b1, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus({24'h0, a}, 1'b0, 32'h0, q);
        chk(q, e);
    endtask : rd

    task automatic poke(input logic [11:0] a, input logic [7:0] v);
        wr(OFS_MADDR, {20'h0, a});
        wr(OFS_MDATA, {24'h0, v});
    endtask : poke

    task automatic peek(input logic [11:0] a, input logic [7:0] e);
        wr(OFS_MADDR, {20'h0, a});
        rd(OFS_MDATA, {24'h0, e});
    endtask : peek

    // poll busy with a bound; a hang ends the run
    task automatic settle;
        logic [31:0] q;
        for (int i = 0; i < 20; i++)
        begin
            bus({24'h0, OFS_STATUS}, 1'b0, 32'h0, q);
            if (q[STAT_BUSY_BIT] === 1'b0) return;
        end
        miscompares++;
        $display("BAD %0t instruction never finished", $time);
        give_verdict;
    endtask : settle

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        logic [31:0] q;
        for (int a = 0; a <= 32; a += 4)
            if (a != 28) rd(8'(a), 32'h0);
        wr(8'h24, 32'hFF);
        rd(8'h24, 32'h0);
        bus(32'h108, 1'b0, 32'h0, q);
        chk(q, 32'h0);
    endtask : t_reset

    task automatic t_sub;
        logic [7:0] fv[4] = '{8'h19, 8'h1B, 8'h03, 8'h80};
        logic [7:0] wv[4] = '{8'h0D, 8'h1A, 8'h0E, 8'h01};
        logic [7:0] rv[4] = '{8'h0C, 8'h00, 8'hF5, 8'h7F};
        logic [4:0] gv[4] = '{5'h01, 5'h07, 5'h10, 5'h09};
        logic       cv[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
        logic       dv[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        wr(OFS_BANK, 32'h2);
        for (int i = 0; i < 4; i++)
        begin
            poke(12'h234, fv[i]);
            wr(OFS_ACC, {24'h0, wv[i]});
            wr(OFS_FLAGS, {31'h0, cv[i]});
            wr(OFS_INSTR, {16'h0, OPC_SUB_BORROW, dv[i], 1'b1, 8'h34});
            settle;
            rd(OFS_FLAGS, {27'h0, gv[i]});
            rd(OFS_STATUS, {16'h0, rv[i], 8'h00});
            rd(OFS_ACC, {24'h0, dv[i] ? wv[i] : rv[i]});
            peek(12'h234, dv[i] ? rv[i] : fv[i]);
        end
    endtask : t_sub

    task automatic t_swap;
        logic        xv[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        logic        av[5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
        logic        dv[5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        logic [7:0]  fv[5] = '{8'h70, 8'h20, 8'h5F, 8'h60, 8'h53};
        logic [11:0] ad[5] = '{12'hF70, 12'h020, 12'h15F, 12'hF60, 12'h353};
        logic [7:0]  v;
        wr(OFS_INDEX, 32'h100);
        wr(OFS_BANK, 32'h3);
        wr(OFS_FLAGS, 32'h15);
        for (int i = 0; i < 5; i++)
        begin
            v = 8'h5A + 8'(i);
            wr(OFS_CTRL, {31'h0, xv[i]});
            poke(ad[i], v);
            wr(OFS_INSTR, {16'h0, OPC_NIB_SWAP, dv[i], av[i], fv[i]});
            settle;
            peek(ad[i], dv[i] ? {v[3:0], v[7:4]} : v);
            if (!dv[i]) rd(OFS_ACC, {24'h0, v[3:0], v[7:4]});
            rd(OFS_FLAGS, 32'h15);
        end
    endtask : t_swap

    task automatic t_refuse;
        logic [31:0] q;
        wr(OFS_INSTR, 32'h5C00);
        settle;
        bus({24'h0, OFS_STATUS}, 1'b0, 32'h0, q);
        chk({31'h0, q[STAT_ILL_BIT]}, 32'h1);
        wr(OFS_ACC, 32'h11);
        wr(OFS_INSTR, {16'h0, OPC_NIB_SWAP, 2'b11, 8'h34});
        wr(OFS_ACC, 32'h77);
        settle;
        rd(OFS_ACC, 32'h11);
    endtask : t_refuse

    // ------------------------------------------------------------
    // clock, reset and main sequence
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial
    begin
        rst_n  = 1'b0;
        hsel   = 1'b0;
        htrans = 2'b00;
        haddr  = 32'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset;
        t_sub;
        t_swap;
        t_refuse;
        give_verdict;
    end
endmodule : tb

`default_nettype wire

// ### rtl/bsn_exec.sv
/*
 * Execution block for the borrow-subtract and nibble-exchange byte
 * instructions, with its file memory and an AHB-Lite register slave.
 * Assumes one 40 MHz clock, an asynchronous active-low reset and a single
 * AHB-Lite master doing whole-word single transfers.
 */
// Implementation choices: the register offsets and register access over AHB-Lite.
// Notes on behaviour
// - borrow subtract: file minus acc minus not-carry, two's complement
// - nibble exchange swaps file nibbles into result; flags untouched
// - destination bit 0 writes accumulator, 1 writes the file register
// - access bit 0 uses access bank, 1 uses bank_select_pointer bank
// - extended set, access bit 0, operand up to 95: indexed offset address
// - one word, one cycle: decode, read, process, write in four phases
`timescale 1ns/1ps
`default_nettype none

module bsn_exec
    import bsn_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0]  file_mem [MEM_DEPTH];
    bsn_state_t  state;
    bsn_decode_t dec;
    bsn_flags_t  flags;
    logic        ext_en;
    logic [15:0] opcode;
    logic [7:0]  acc;
    logic [3:0]  bank_select_pointer;
    logic [11:0] index_base;
    logic [11:0] mem_ptr;
    logic        illegal;
    logic [7:0]  operand;
    logic [7:0]  result;
    bsn_flags_t  res_flags;
    logic        wr_pend;
    logic [7:0]  wr_ofs;

    // ------------------------------------------------------------------
    // file address resolution
    // ------------------------------------------------------------------
    function automatic logic [11:0] resolve_addr(
        input logic [7:0]  f,
        input logic        a,
        input logic        ext,
        input logic [3:0]  bank,
        input logic [11:0] base
    );
        logic [11:0] r;
        if (a)
            r = {bank, f};
        else if (ext && (f <= INDEX_LIMIT))
            r = base + {4'h0, f};
        else if (f < ACCESS_SPLIT)
            r = {4'h0, f};
        else
            r = {ACCESS_HI_BNK, f};
        return r;
    endfunction : resolve_addr

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    wire        addr_phase = hsel && htrans[1] && hready;
    wire        busy       = (state != ST_IDLE);
    wire        bus_wr     = wr_pend && !busy; // writes refused while busy
    wire        wr_ctrl    = bus_wr && (wr_ofs == OFS_CTRL);
    wire        wr_instr   = bus_wr && (wr_ofs == OFS_INSTR);
    wire        wr_acc     = bus_wr && (wr_ofs == OFS_ACC);
    wire        wr_bank    = bus_wr && (wr_ofs == OFS_BANK);
    wire        wr_flags   = bus_wr && (wr_ofs == OFS_FLAGS);
    wire        wr_index   = bus_wr && (wr_ofs == OFS_INDEX);
    wire        wr_maddr   = bus_wr && (wr_ofs == OFS_MADDR);
    wire        wr_mdata   = bus_wr && (wr_ofs == OFS_MDATA);

    assign hreadyout = 1'b1; // every register answers with no wait state
    assign hresp     = 1'b0;

    // ------------------------------------------------------------------
    // read mux, sampled in the address phase
    // ------------------------------------------------------------------
    logic [31:0] next_rdata;
    wire  [31:0] status_word = {16'h0000, result, 6'h00, illegal, busy};

    always_comb
    begin
        unique case (haddr[7:0])
            OFS_CTRL:   next_rdata = {31'h0, ext_en};
            OFS_INSTR:  next_rdata = {16'h0000, opcode};
            OFS_ACC:    next_rdata = {24'h0, acc};
            OFS_BANK:   next_rdata = {28'h0, bank_select_pointer};
            OFS_FLAGS:  next_rdata = {27'h0, flags};
            OFS_INDEX:  next_rdata = {20'h0, index_base};
            OFS_MADDR:  next_rdata = {20'h0, mem_ptr};
            OFS_MDATA:  next_rdata = {24'h0, file_mem[mem_ptr]};
            OFS_STATUS: next_rdata = status_word;
            default:    next_rdata = 32'h0000_0000;
        endcase
        if (haddr[31:8] != 24'h00_0000)
            next_rdata = 32'h0000_0000; // unmapped reads as zero
    end

    // address phase capture; read data valid in the data phase
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_pend <= 1'b0;
            wr_ofs  <= 8'h00;
            hrdata  <= 32'h0000_0000;
        end
        else
        begin
            wr_pend <= addr_phase && hwrite && (haddr[31:8] == 24'h00_0000);
            wr_ofs  <= haddr[7:0];
            if (addr_phase && !hwrite)
                hrdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // opcode decode and datapath
    // ------------------------------------------------------------------
    wire [5:0] op_hi     = opcode[15:10];
    wire       op_sub    = (op_hi == OPC_SUB_BORROW);
    wire       op_swap   = (op_hi == OPC_NIB_SWAP);
    wire [11:0] op_addr  = resolve_addr(opcode[7:0], opcode[OP_A_BIT],
                                        ext_en, bank_select_pointer,
                                        index_base);

    // carry is not-borrow, so the subtrahend gains the inverted carry
    wire [8:0] diff      = {1'b0, operand} - {1'b0, acc}
                           - {8'h00, ~flags.c};
    wire [4:0] diff_lo   = {1'b0, operand[3:0]} - {1'b0, acc[3:0]}
                           - {4'h0, ~flags.c};
    wire [7:0] swapped   = {operand[3:0], operand[7:4]};

    bsn_flags_t sub_flags;
    assign sub_flags.n                    = diff[7];
    assign sub_flags.signed_overflow_flag = (operand[7] != acc[7])
                                            && (diff[7] != operand[7]);
    assign sub_flags.z                    = (diff[7:0] == 8'h00);
    assign sub_flags.digit_carry_flag     = ~diff_lo[4];
    assign sub_flags.c                    = ~diff[8]; // cleared on borrow

    // ------------------------------------------------------------------
    // phase sequencer: one phase per clock, Q1 to Q4
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            state <= ST_IDLE;
        else
        begin
            unique case (state)
                ST_IDLE: if (wr_instr) state <= ST_Q1;
                ST_Q1:   state <= (op_sub || op_swap) ? ST_Q2 : ST_IDLE;
                ST_Q2:   state <= ST_Q3;
                ST_Q3:   state <= ST_Q4;
                ST_Q4:   state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // decode in Q1, read in Q2, process in Q3
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dec       <= '0;
            illegal   <= 1'b0;
            operand   <= RST_BYTE;
            result    <= RST_BYTE;
            res_flags <= '0;
        end
        else
        begin
            if (state == ST_Q1)
            begin
                dec.is_sub  <= op_sub;
                dec.to_file <= opcode[OP_D_BIT];
                dec.addr    <= op_addr;
                illegal     <= !(op_sub || op_swap);
            end
            if (state == ST_Q2)
                operand <= file_mem[dec.addr];
            if (state == ST_Q3)
            begin
                result    <= dec.is_sub ? diff[7:0] : swapped;
                res_flags <= dec.is_sub ? sub_flags : flags;
            end
        end
    end

    // ------------------------------------------------------------------
    // software registers and Q4 write-back
    // ------------------------------------------------------------------
    wire q4_acc  = (state == ST_Q4) && !dec.to_file;
    wire q4_file = (state == ST_Q4) && dec.to_file;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ext_en              <= 1'b0;
            opcode              <= RST_OPCODE;
            acc                 <= RST_BYTE;
            bank_select_pointer <= RST_BANK;
            flags               <= '0;
            index_base          <= RST_ADDR;
            mem_ptr             <= RST_ADDR;
        end
        else
        begin
            if (wr_ctrl)
                ext_en <= hwdata[CTRL_EXT_BIT];
            if (wr_instr)
                opcode <= hwdata[15:0];
            if (wr_acc)
                acc <= hwdata[7:0];
            else if (q4_acc)
                acc <= result;
            if (wr_bank)
                bank_select_pointer <= hwdata[3:0];
            if (wr_flags)
                flags <= hwdata[4:0];
            else if ((state == ST_Q4) && dec.is_sub)
                flags <= res_flags;
            if (wr_index)
                index_base <= hwdata[11:0];
            if (wr_maddr)
                mem_ptr <= hwdata[11:0];
        end
    end

    // file memory has no reset; software loads it through the window
    always_ff @(posedge clk)
    begin
        if (q4_file)
            file_mem[dec.addr] <= result;
        else if (wr_mdata)
            file_mem[mem_ptr] <= hwdata[7:0];
    end

    // hsize is unused: only whole-word transfers are expected
    wire unused_ok = &{1'b0, hsize, htrans[0]};

endmodule : bsn_exec

`default_nettype wire

// ### rtl/bsn_pkg.sv
/*
 * Package for the borrow-subtract / nibble-exchange execution block:
 * register offsets, field positions, opcode patterns, reset values,
 * state codes and the carrier types.
 * Assumes a single 40 MHz clock and an AHB-Lite master with 32-bit data.
 */
`default_nettype none

package bsn_pkg;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00; // extended set enable
    localparam logic [7:0] OFS_INSTR  = 8'h04; // opcode, write starts
    localparam logic [7:0] OFS_ACC    = 8'h08; // accumulator
    localparam logic [7:0] OFS_BANK   = 8'h0C; // bank_select_pointer
    localparam logic [7:0] OFS_FLAGS  = 8'h10; // status flags
    localparam logic [7:0] OFS_INDEX  = 8'h14; // indexed offset base
    localparam logic [7:0] OFS_MADDR  = 8'h18; // file memory pointer
    localparam logic [7:0] OFS_MDATA  = 8'h1C; // file memory byte
    localparam logic [7:0] OFS_STATUS = 8'h20; // busy, illegal, result

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CTRL_EXT_BIT   = 0;
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_ILL_BIT   = 1;
    localparam int STAT_RES_LSB   = 8;
    localparam int OP_D_BIT       = 9;
    localparam int OP_A_BIT       = 8;

    // ------------------------------------------------------------------
    // opcode patterns (upper six bits of the 16-bit word)
    // ------------------------------------------------------------------
    localparam logic [5:0] OPC_SUB_BORROW = 6'h16; // 0101 10
    localparam logic [5:0] OPC_NIB_SWAP   = 6'h0E; // 0011 10

    // ------------------------------------------------------------------
    // addressing constants and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  ACCESS_SPLIT  = 8'h60; // first upper access byte
    localparam logic [7:0]  INDEX_LIMIT   = 8'h5F; // 95, last indexed offset
    localparam logic [3:0]  ACCESS_HI_BNK = 4'hF;  // upper access half bank
    localparam logic [7:0]  RST_BYTE      = 8'h00;
    localparam logic [3:0]  RST_BANK      = 4'h0;
    localparam logic [11:0] RST_ADDR      = 12'h000;
    localparam logic [15:0] RST_OPCODE    = 16'h0000;
    localparam int          MEM_DEPTH     = 4096;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_Q1   = 3'b001,
        ST_Q2   = 3'b010,
        ST_Q3   = 3'b011,
        ST_Q4   = 3'b100
    } bsn_state_t;

    typedef struct packed {
        logic n;
        logic signed_overflow_flag;
        logic z;
        logic digit_carry_flag;
        logic c;
    } bsn_flags_t;

    typedef struct packed {
        logic        is_sub;   // borrow subtract, else nibble exchange
        logic        to_file;  // destination select bit
        logic [11:0] addr;     // resolved file address
    } bsn_decode_t;

endpackage : bsn_pkg

`default_nettype wire
